// [include/srsi_pkg.sv]
package srsi_pkg;

	////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned FLASH_MS = 500;
	localparam int unsigned PAUSE_MS = 2000;
	localparam int unsigned HALF_CYC = FLASH_MS * (CLK_HZ / 1000);
	localparam logic [4:0] PAUSE_SLOTS = 5'(PAUSE_MS / FLASH_MS);
	localparam logic [1:0] INIT_CHECK = 2'h2;
	localparam logic [1:0] INIT_DONE = 2'h3;

	////////////////////////////////////////////////////////////////////
	// flash codes
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_CFG = 3'h1;
	localparam logic [2:0] CODE_SW = 3'h2;
	localparam logic [2:0] CODE_JOIN = 3'h3;
	localparam logic [2:0] CODE_RETRIG = 3'h4;
	localparam logic [2:0] CODE_CROSS = 3'h4;

	////////////////////////////////////////////////////////////////////
	// apb map
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_STATUS = 12'h004;
	localparam logic [11:0] A_IRQ_ST = 12'h008;
	localparam logic [11:0] A_IRQ_MASK = 12'h00c;
	localparam int CTRL_SINGLE = 0;
	localparam int CTRL_DUAL = 1;
	localparam int CTRL_TIMER = 2;
	localparam int CTRL_W = 3;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam int EV_SOLID = 0;
	localparam int EV_NONREC = 1;
	localparam int EV_RECOV = 2;
	localparam int EV_OUT = 3;
	localparam int EV_W = 4;
	localparam int ST_MODE_LSB = 0;
	localparam int ST_CODE_LSB = 8;
	localparam int ST_LED_LSB = 16;

	////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [4:0] {
		M_OK = 5'h01,
		M_RECOV = 5'h02,
		M_NONREC = 5'h04,
		M_CONFIG = 5'h08,
		M_SOLID = 5'h10
	} srsi_mode_t;

	typedef struct packed {
		logic in1;
		logic in2;
		logic timing_select_input;
		logic timing_select_companion;
		logic single_wire_link_input;
		logic reset_button;
		logic rail_short;
		logic cap_warn;
		logic cross_fault;
		logic power_glitch;
		logic [3:0] cfg_switch;
	} srsi_pins_t;

	typedef struct packed {
		logic outputs_on;
		logic await_reset;
		logic timing_active;
		logic timer_done;
		logic cfg_mode;
		logic internal_fault;
		logic single_wire_link_output;
		logic recov_fault;
		logic [2:0] recov_code;
		logic [3:0] stored_cfg;
	} srsi_core_t;

	typedef struct packed {
		logic power_fault_green;
		logic power_fault_red;
		logic in1;
		logic in2;
		logic timing_select;
		logic link_in;
		logic link_out;
		logic out;
	} srsi_led_t;

endpackage

// [logic/srsi_status_top.sv]
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps

module srsi_status_top
	import srsi_pkg::*;
#(
	parameter int unsigned HALF_CYCLES = HALF_CYC
) (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire srsi_pins_t pins_in,
	input wire srsi_core_t core_in,
	output srsi_led_t leds_out,
	output logic aux_status_output_out,
	output logic irq_out
);

	////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		srsi_pins_t s1;
		srsi_pins_t s2;
		logic link_prev;
		logic rst_prev;
		logic out_prev;
		logic [1:0] init_q;
		logic solid_q;
		logic nonrec_q;
		logic [2:0] nonrec_code_q;
		logic sw_q;
		logic join_q;
		logic retrig_q;
		logic rec_q;
		logic [2:0] rec_code_q;
		srsi_mode_t mode_q;
		logic [2:0] code_q;
		logic [31:0] cnt_q;
		logic half_q;
		logic [4:0] slot_q;
		srsi_led_t led_q;
		logic aux_q;
		logic [CTRL_W-1:0] ctrl_q;
		logic [EV_W-1:0] ist_q;
		logic [EV_W-1:0] imask_q;
		logic [31:0] prdata_q;
		logic pslverr_q;
	} srsi_state_t;

	srsi_state_t st_q;
	srsi_state_t st_d;
	logic link_rise;
	logic link_fall;
	logic rst_rise;
	logic running;
	logic mismatch;
	logic timer_v;
	logic tick;
	logic red_code;
	logic wr;
	logic [EV_W-1:0] ev;
	logic [31:0] rd;

	function automatic logic [4:0] slots_of(input logic [2:0] n);
		return {1'b0, n, 1'b0} + PAUSE_SLOTS;
	endfunction

	function automatic logic flash_on(input logic [4:0] slot, input logic [2:0] n);
		return (slot < {1'b0, n, 1'b0}) && !slot[0];
	endfunction

	////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_d = st_q;
		st_d.s1 = pins_in;
		st_d.s2 = st_q.s1;
		st_d.link_prev = st_q.s2.single_wire_link_input;
		st_d.rst_prev = st_q.s2.reset_button;
		st_d.out_prev = core_in.outputs_on;
		link_rise = st_q.s2.single_wire_link_input && !st_q.link_prev;
		link_fall = !st_q.s2.single_wire_link_input && st_q.link_prev;
		rst_rise = st_q.s2.reset_button && !st_q.rst_prev;
		running = st_q.init_q == INIT_DONE;
		mismatch = st_q.s2.cfg_switch != core_in.stored_cfg;
		timer_v = st_q.ctrl_q[CTRL_TIMER];
		if (!running) begin
			st_d.init_q = st_q.init_q + 2'h1;
		end

		// fatal classes
		if (core_in.internal_fault || st_q.s2.power_glitch) begin
			st_d.solid_q = 1'b1;
		end
		if (st_q.s2.rail_short) begin
			st_d.solid_q = 1'b1;
		end
		if (st_q.ctrl_q[CTRL_SINGLE] && st_q.s2.cap_warn) begin
			st_d.solid_q = 1'b1;
		end

		// non-recoverable codes, first one kept
		if (!st_q.nonrec_q) begin
			if (st_q.init_q == INIT_CHECK && mismatch && !core_in.cfg_mode) begin
				st_d.nonrec_q = 1'b1;
				st_d.nonrec_code_q = CODE_SW;
			end else if (st_q.s2.cross_fault) begin
				st_d.nonrec_q = 1'b1;
				st_d.nonrec_code_q = CODE_CROSS;
			end
		end

		// self-clearing recoverable faults
		if (running && !st_q.nonrec_q && !core_in.cfg_mode) begin
			st_d.sw_q = mismatch;
		end
		st_d.join_q = timer_v && running && st_q.s2.timing_select_companion;
		if (core_in.timer_done || link_fall) begin
			st_d.retrig_q = 1'b0;
		end
		if (timer_v && !st_q.s2.timing_select_input && core_in.timing_active
				&& link_rise) begin
			st_d.retrig_q = 1'b1;
		end

		// reset-cleared recoverable fault
		if (rst_rise && !core_in.recov_fault) begin
			st_d.rec_q = 1'b0;
		end
		if (core_in.recov_fault) begin
			st_d.rec_q = 1'b1;
			st_d.rec_code_q = core_in.recov_code;
		end

		// display mode and code
		if (st_d.solid_q) begin
			st_d.mode_q = M_SOLID;
			st_d.code_q = CODE_NONE;
		end else if (core_in.cfg_mode) begin
			st_d.mode_q = M_CONFIG;
			st_d.code_q = CODE_CFG;
		end else if (st_d.nonrec_q) begin
			st_d.mode_q = M_NONREC;
			st_d.code_q = st_d.nonrec_code_q;
		end else if (st_d.rec_q) begin
			st_d.mode_q = M_RECOV;
			st_d.code_q = st_d.rec_code_q;
		end else if (st_d.sw_q) begin
			st_d.mode_q = M_RECOV;
			st_d.code_q = CODE_SW;
		end else if (st_d.join_q) begin
			st_d.mode_q = M_RECOV;
			st_d.code_q = CODE_JOIN;
		end else if (st_d.retrig_q) begin
			st_d.mode_q = M_RECOV;
			st_d.code_q = CODE_RETRIG;
		end else begin
			st_d.mode_q = M_OK;
			st_d.code_q = CODE_NONE;
		end

		// half-second slots, code sequencer
		tick = st_q.cnt_q == HALF_CYCLES - 1;
		st_d.cnt_q = tick ? 32'h0 : st_q.cnt_q + 32'h1;
		if (tick) begin
			st_d.half_q = !st_q.half_q;
			if (st_q.slot_q >= slots_of(st_q.code_q) - 5'h1) begin
				st_d.slot_q = 5'h0;
			end else begin
				st_d.slot_q = st_q.slot_q + 5'h1;
			end
		end
		if (st_d.code_q != st_q.code_q) begin
			st_d.slot_q = 5'h0;
		end
		red_code = flash_on(st_d.slot_q, st_d.code_q);

		// indicators
		st_d.led_q.in1 = st_q.s2.in1;
		st_d.led_q.in2 = st_q.ctrl_q[CTRL_DUAL] && st_q.s2.in2;
		st_d.led_q.timing_select = timer_v && st_q.s2.timing_select_input;
		if (timer_v && core_in.timing_active) begin
			st_d.led_q.link_in = st_q.half_q;
		end else begin
			st_d.led_q.link_in = st_q.s2.single_wire_link_input;
		end
		st_d.led_q.link_out = core_in.single_wire_link_output;
		if (core_in.await_reset && !core_in.outputs_on) begin
			st_d.led_q.out = st_q.half_q;
		end else begin
			st_d.led_q.out = core_in.outputs_on;
		end
		st_d.aux_q = !core_in.outputs_on;
		unique case (st_d.mode_q)
			M_OK: begin
				st_d.led_q.power_fault_green = 1'b1;
				st_d.led_q.power_fault_red = 1'b0;
			end
			M_RECOV: begin
				st_d.led_q.power_fault_green = 1'b1;
				st_d.led_q.power_fault_red = red_code;
			end
			M_NONREC, M_CONFIG: begin
				st_d.led_q.power_fault_green = 1'b0;
				st_d.led_q.power_fault_red = red_code;
			end
			M_SOLID: begin
				st_d.led_q.power_fault_green = 1'b0;
				st_d.led_q.power_fault_red = 1'b1;
			end
		endcase

		// events
		ev = '0;
		ev[EV_SOLID] = st_d.solid_q && !st_q.solid_q;
		ev[EV_NONREC] = st_d.nonrec_q && !st_q.nonrec_q;
		ev[EV_RECOV] = st_d.mode_q == M_RECOV && st_q.mode_q != M_RECOV;
		ev[EV_OUT] = core_in.outputs_on != st_q.out_prev;

		// apb slave
		wr = psel_in && penable_in && pwrite_in;
		if (wr) begin
			unique case (paddr_in)
				A_CTRL: st_d.ctrl_q = pwdata_in[CTRL_W-1:0];
				A_IRQ_ST: st_d.ist_q = st_q.ist_q & ~pwdata_in[EV_W-1:0];
				A_IRQ_MASK: st_d.imask_q = pwdata_in[EV_W-1:0];
				default: ;
			endcase
		end
		st_d.ist_q = st_d.ist_q | ev;
		rd = 32'h0;
		rd[ST_MODE_LSB +: 5] = st_q.mode_q;
		rd[ST_CODE_LSB +: 3] = st_q.code_q;
		rd[ST_LED_LSB +: 8] = st_q.led_q;
		if (psel_in && !penable_in) begin
			st_d.pslverr_q = 1'b0;
			unique case (paddr_in)
				A_CTRL: st_d.prdata_q = {29'h0, st_q.ctrl_q};
				A_STATUS: st_d.prdata_q = rd;
				A_IRQ_ST: st_d.prdata_q = {28'h0, st_q.ist_q};
				A_IRQ_MASK: st_d.prdata_q = {28'h0, st_q.imask_q};
				default: begin
					st_d.prdata_q = 32'h0;
					st_d.pslverr_q = 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			st_q <= '0;
			st_q.mode_q <= M_OK;
			st_q.ctrl_q <= CTRL_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign leds_out = st_q.led_q;
	assign aux_status_output_out = st_q.aux_q;
	assign prdata_out = st_q.prdata_q;
	assign pready_out = psel_in && penable_in;
	assign pslverr_out = psel_in && penable_in && st_q.pslverr_q;
	assign irq_out = |(st_q.ist_q & st_q.imask_q);

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_timing;
		st_q.ctrl_q[CTRL_TIMER] && core_in.timing_active;
	endsequence

	sequence s_waiting;
		core_in.await_reset && !core_in.outputs_on;
	endsequence

	a_nonrec_sticky: assert property (
		st_q.nonrec_q && !st_q.solid_q && !core_in.cfg_mode
		|=> st_q.nonrec_q && !leds_out.power_fault_green)
		else $error("non-recoverable fault lost or green lit");
	a_reset_clears: assert property (
		st_q.rec_q && rst_rise && !core_in.recov_fault |=> !st_q.rec_q)
		else $error("reset did not clear recoverable fault");
	a_solid_sticky: assert property (
		st_q.solid_q |=> st_q.solid_q && st_q.mode_q == M_SOLID)
		else $error("solid red state left");
	a_rail_short_red: assert property (
		st_q.s2.rail_short |-> ##2 (leds_out.power_fault_red && !leds_out.power_fault_green))
		else $error("rail short not shown solid red");
	a_single_cap_red: assert property (
		st_q.ctrl_q[CTRL_SINGLE] && st_q.s2.cap_warn |=> st_q.solid_q)
		else $error("capacitance warning not latched");
	a_in1_follow: assert property (
		leds_out.in1 == $past(st_q.s2.in1))
		else $error("input one indicator wrong");
	a_in2_open_off: assert property (
		!st_q.s2.in2 |=> !leds_out.in2)
		else $error("input two indicator lit while open");
	a_tsel_follow: assert property (
		st_q.ctrl_q[CTRL_TIMER] && st_q.s2.timing_select_input |=> leds_out.timing_select)
		else $error("timing select indicator dark");
	a_link_follow: assert property (
		!core_in.timing_active |=> leds_out.link_in == $past(st_q.s2.single_wire_link_input))
		else $error("link indicator wrong");
	a_timing_flash: assert property (
		s_timing ##1 s_timing |-> leds_out.link_in == $past(st_q.half_q))
		else $error("link indicator not flashing");
	a_wait_flash: assert property (
		s_waiting |=> leds_out.out == $past(st_q.half_q))
		else $error("output indicator not flashing");
	a_aux_inverse: assert property (
		core_in.outputs_on |=> !aux_status_output_out && (leds_out.out || !core_in.outputs_on))
		else $error("aux output not complement");
	a_cfg_code: assert property (
		st_q.mode_q == M_CONFIG |-> st_q.code_q == CODE_CFG && !leds_out.power_fault_green)
		else $error("configuration code wrong");
	a_sw_change: assert property (
		running && mismatch && !st_q.nonrec_q && !core_in.cfg_mode |=> st_q.sw_q)
		else $error("switch change not flagged");
	a_join_clears: assert property (
		st_q.join_q && !st_q.s2.timing_select_companion |=> !st_q.join_q)
		else $error("joined terminal fault not cleared");
	a_retrig_set: assert property (
		st_q.ctrl_q[CTRL_TIMER] && !st_q.s2.timing_select_input
		&& core_in.timing_active && link_rise |=> st_q.retrig_q)
		else $error("retrigger fault not set");
	a_boot_mismatch: assert property (
		st_q.init_q == INIT_CHECK && mismatch && !core_in.cfg_mode |=> st_q.nonrec_q)
		else $error("power-up mismatch not flagged");
	a_slot_bound: assert property (
		st_q.slot_q < slots_of(st_q.code_q))
		else $error("flash slot out of range");
	a_aux_high: assert property (
		reset_n_in && !core_in.outputs_on |=> aux_status_output_out)
		else $error("aux output low while outputs off");
	a_in2_closed_on: assert property (
		st_q.ctrl_q[CTRL_DUAL] && st_q.s2.in2 |=> leds_out.in2)
		else $error("input two indicator dark while closed");
	a_retrig_clear: assert property (
		core_in.timer_done && !link_rise |=> !st_q.retrig_q)
		else $error("retrigger fault not cleared on expiry");

endmodule

// [dv/srsi_field_model.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////
// field wiring, reset button and upstream relay, one clock delay
module srsi_field_model
	import srsi_pkg::*;
(
	input wire logic core_clk_in,
	input wire srsi_pins_t want_in,
	output srsi_pins_t pins_out
);
	always_ff @(posedge core_clk_in) begin
		pins_out <= want_in;
		// terminal join only when the bench asks for it
		pins_out.timing_select_companion <= want_in.timing_select_companion;
	end
endmodule

// [dv/safety_relay_status_indicators_bench.sv]
`timescale 1ns/1ps

module safety_relay_status_indicators_bench;
	import srsi_pkg::*;
	localparam int H = 4;
	logic core_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, aux, irq, er;
	srsi_pins_t want = 14'h005;
	srsi_pins_t pins;
	srsi_core_t core = 15'h005;
	srsi_led_t leds;
	int err_count = 0;
	int check_count = 0;
	int n;

	always #12.5 core_clk_in = ~core_clk_in;

	srsi_field_model field (.core_clk_in(core_clk_in), .want_in(want), .pins_out(pins));

	srsi_status_top #(.HALF_CYCLES(H)) uut (
		.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .pins_in(pins), .core_in(core), .leds_out(leds),
		.aux_status_output_out(aux), .irq_out(irq)
	);

	////////////////////////////////////////////////////////////////////
	// tasks
	task summarize();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task cyc(input int k);
		repeat (k) @(posedge core_clk_in);
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_in);
		penable <= 1'b1;
		@(posedge core_clk_in);
		while (pready !== 1'b1) begin
			@(posedge core_clk_in);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task st(input logic [4:0] m, input logic [2:0] c);
		apb(1'b0, A_STATUS, 32'h0);
		chk("mode", m, rd[4:0]);
		chk("code", c, rd[10:8]);
	endtask

	task rises(input int b, input int k, output int c);
		logic [7:0] lv;
		logic p;
		@(negedge core_clk_in);
		lv = leds;
		p = lv[b];
		c = 0;
		repeat (k) begin
			@(negedge core_clk_in);
			lv = leds;
			if (lv[b] === 1'b1 && p === 1'b0) c++;
			p = lv[b];
		end
		@(posedge core_clk_in);
	endtask

	task pwr();
		reset_n_in <= 1'b0;
		cyc(4);
		reset_n_in <= 1'b1;
		cyc(8);
	endtask

	////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		#(25 * 60000);
		err_count++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////
	// tests
	initial begin
		cyc(4);
		reset_n_in <= 1'b1;
		cyc(8);
		apb(1'b0, A_CTRL, 32'h0);
		chk("ctrl", 32'h0, rd);
		apb(1'b0, A_IRQ_MASK, 32'h0);
		chk("mask", 32'h0, rd);
		apb(1'b1, 12'h010, 32'hffff_ffff);
		chk("err", 32'h1, er);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", 32'h0, rd);
		st(M_OK, CODE_NONE);
		chk("leds", 8'h80, leds);
		apb(1'b1, A_CTRL, 32'h6);
		want.in1 <= 1'b1;
		want.timing_select_input <= 1'b1;
		want.single_wire_link_input <= 1'b1;
		core.outputs_on <= 1'b1;
		core.single_wire_link_output <= 1'b1;
		cyc(6);
		chk("leds", 8'haf, leds);
		chk("aux", 32'h0, aux);
		want.in2 <= 1'b1;
		cyc(6);
		chk("leds", 8'hbf, leds);
		want <= 14'h005;
		core <= 15'h005;
		cyc(6);
		chk("leds", 8'h80, leds);
		chk("aux", 32'h1, aux);
		apb(1'b1, A_IRQ_MASK, 32'h8);
		cyc(2);
		chk("irq", 32'h1, irq);
		apb(1'b1, A_IRQ_ST, 32'h8);
		cyc(2);
		chk("irq", 32'h0, irq);
		apb(1'b1, A_IRQ_MASK, 32'h0);
		core.outputs_on <= 1'b1;
		cyc(3);
		apb(1'b0, A_IRQ_ST, 32'h0);
		chk("irq_st", 32'h8, rd & 32'h8);
		chk("irq", 32'h0, irq);
		core.outputs_on <= 1'b0;
		core.await_reset <= 1'b1;
		cyc(3);
		rises(0, 4 * H, n);
		chk("out_flash", 32'h2, n);
		core.await_reset <= 1'b0;
		want.single_wire_link_input <= 1'b1;
		core.timing_active <= 1'b1;
		cyc(6);
		rises(2, 4 * H, n);
		chk("link_flash", 32'h2, n);
		want.single_wire_link_input <= 1'b0;
		cyc(6);
		want.single_wire_link_input <= 1'b1;
		cyc(6);
		st(M_RECOV, CODE_RETRIG);
		rises(6, 12 * H, n);
		chk("flashes", 32'h4, n);
		chk("green", 32'h1, leds.power_fault_green);
		want.single_wire_link_input <= 1'b0;
		cyc(6);
		st(M_OK, CODE_NONE);
		want.single_wire_link_input <= 1'b1;
		cyc(6);
		st(M_RECOV, CODE_RETRIG);
		core.timer_done <= 1'b1;
		cyc(1);
		core.timer_done <= 1'b0;
		cyc(3);
		st(M_OK, CODE_NONE);
		want.single_wire_link_input <= 1'b0;
		cyc(6);
		core.timing_active <= 1'b0;
		want.timing_select_companion <= 1'b1;
		cyc(6);
		st(M_RECOV, CODE_JOIN);
		rises(6, 10 * H, n);
		chk("flashes", 32'h3, n);
		chk("green", 32'h1, leds.power_fault_green);
		want.timing_select_companion <= 1'b0;
		cyc(6);
		st(M_OK, CODE_NONE);
		want.cfg_switch <= 4'h6;
		cyc(6);
		st(M_RECOV, CODE_SW);
		rises(6, 8 * H, n);
		chk("flashes", 32'h2, n);
		chk("green", 32'h1, leds.power_fault_green);
		want.cfg_switch <= 4'h5;
		cyc(6);
		st(M_OK, CODE_NONE);
		core.recov_fault <= 1'b1;
		core.recov_code <= 3'h2;
		cyc(3);
		apb(1'b0, A_STATUS, 32'h0);
		chk("mode", M_RECOV, rd[4:0]);
		chk("green", 32'h1, leds.power_fault_green);
		core.recov_fault <= 1'b0;
		cyc(6);
		apb(1'b0, A_STATUS, 32'h0);
		chk("mode", M_RECOV, rd[4:0]);
		want.reset_button <= 1'b1;
		cyc(6);
		want.reset_button <= 1'b0;
		cyc(4);
		apb(1'b0, A_STATUS, 32'h0);
		chk("mode", M_OK, rd[4:0]);
		core.cfg_mode <= 1'b1;
		cyc(3);
		st(M_CONFIG, CODE_CFG);
		rises(6, 6 * H, n);
		chk("flashes", 32'h1, n);
		core.cfg_mode <= 1'b0;
		pwr();
		apb(1'b1, A_IRQ_MASK, 32'h2);
		want.cross_fault <= 1'b1;
		cyc(6);
		st(M_NONREC, CODE_CROSS);
		chk("green", 32'h0, leds.power_fault_green);
		chk("irq", 32'h1, irq);
		want.cross_fault <= 1'b0;
		cyc(6);
		st(M_NONREC, CODE_CROSS);
		pwr();
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, A_CTRL, 32'h1);
			case (i)
				0: want.rail_short <= 1'b1;
				1: want.power_glitch <= 1'b1;
				2: want.cap_warn <= 1'b1;
				default: core.internal_fault <= 1'b1;
			endcase
			cyc(6);
			rises(6, 20, n);
			chk("solid", 32'h0, n);
			chk("gr", 32'h1, {leds.power_fault_green, leds.power_fault_red});
			want.rail_short <= 1'b0;
			want.power_glitch <= 1'b0;
			want.cap_warn <= 1'b0;
			core.internal_fault <= 1'b0;
			cyc(6);
			apb(1'b0, A_STATUS, 32'h0);
			chk("mode", M_SOLID, rd[4:0]);
			pwr();
		end
		want.cfg_switch <= 4'h9;
		pwr();
		st(M_NONREC, CODE_SW);
		chk("green", 32'h0, leds.power_fault_green);
		summarize();
	end
endmodule
